// ==== core/apdu_header.sv ====
`timescale 1ns/1ps
`include "chan_defines.svh"

module apdu_header (
  input  wire logic          kind_xfer,
  input  wire logic          term_rsp,
  input  wire chan_pkg::xfer_s req,
  input  wire logic          payload_ok,
  input  wire logic          payload_nz,
  input  wire logic          lc_ok,
  input  wire logic          zero_sent,
  input  wire logic          card_more,
  output chan_pkg::hdr_s     hdr
);

  always_comb begin
    hdr = '0;
    if (!kind_xfer) begin
      hdr.p1     = `P1_TERMINATE;
      hdr.p2     = term_rsp ? `P2_RSP_BLOCK : `P2_CMD_BLOCK;
      hdr.has_lc = !term_rsp;
      hdr.has_le = term_rsp;
      hdr.legal  = term_rsp || (payload_ok && lc_ok);
    end else begin
      // reserved bits zero, retransmit dropped when data present
      hdr.p1 = {req.session, 3'b000, req.data, req.abort,
                req.retx & ~req.data};
      hdr.p2     = req.remain;
      hdr.has_lc = req.data && !req.abort;
      hdr.has_le = !req.data && !req.abort;
      hdr.legal  = req.abort ||
                   (!(req.remain != 8'h00 && !req.data) &&
                    !(req.data && zero_sent && card_more) &&
                    (!req.data || (payload_nz && lc_ok)));
    end
  end

endmodule

// ==== core/chan_defines.svh ====
`ifndef CHAN_DEFINES_SVH
`define CHAN_DEFINES_SVH

// host register offsets
`define REG_CTRL      8'h00
`define REG_SESS      8'h04
`define REG_LEN       8'h08
`define REG_DATA      8'h0C
`define REG_STAT      8'h10
`define REG_SINFO     8'h14
`define REG_RX        8'h18

// control field positions
`define CTRL_START    0
`define CTRL_KIND     1
`define CTRL_RSP      2
`define CTRL_CLEAR    3

// session field positions
`define SESS_RETX     0
`define SESS_ABORT    1
`define SESS_DATA     2
`define SESS_ID_LO    6
`define SESS_REM_LO   8

// command coding
`define P1_TERMINATE  8'h04
`define P2_CMD_BLOCK  8'h80
`define P2_RSP_BLOCK  8'hA0
`define TAG_WRAP      8'h73
`define TAG_MASTER    8'h88
`define TAG_CONN      8'h8B
`define OBJ_VAL_LEN   8'h20
`define OBJ_SIZE      6'd34
`define TAG_XFER      8'h80
`define LEN_EXT       8'h81
`define LEN_SHORT_MAX 9'h07F
`define LC_MAX        9'h0FF

// status words
`define SW_OK         16'h9000
`define SW_MAC_ERR    16'h9862
`define SW1_ONGOING   8'h92
`define SW1_PROACTIVE 8'h91

`endif

// ==== core/chan_pkg.sv ====
package chan_pkg;

  typedef enum {
    S_IDLE, S_CLA, S_INS, S_P1, S_P2, S_LC, S_TAG,
    S_LEN1, S_LEN2, S_BODY, S_LE, S_RESP, S_DONE
  } seq_e;

  typedef struct packed {
    logic [1:0] session;
    logic       data;
    logic       abort;
    logic       retx;
    logic [7:0] remain;
  } xfer_s;

  typedef struct packed {
    logic [7:0] p1;
    logic [7:0] p2;
    logic       has_lc;
    logic       has_le;
    logic       legal;
  } hdr_s;

  typedef struct packed {
    logic       ok;
    logic       mac_err;
    logic       ongoing;
    logic       proactive;
    logic       fail;
    logic       more;
    logic       retx;
    logic       proact;
    logic [1:0] session;
  } sw_s;

endpackage

// ==== core/session_host.sv ====
`timescale 1ns/1ps
`include "chan_defines.svh"

// Operation
// - terminate: p2 80 sends, a0 fetches, payload wrapped in tag 73
// - terminate uses p1 04; lc on command blocks, le on response blocks
// - terminate payload: one master object alone or connection objects
// - master object: tag 88, length 32, 16 identity, 16 mac
// - connection object: tag 8b, length 32, 16 identity, 16 mac
// - transfer case follows data bit; abort makes it header only, no lc or le
// - p1 top bits pick one of four sessions; bits 5..3 zero
// - p1 bit2 data, bit1 abort, bit0 retransmit zero when data
// - p2 holds remaining blocks; nonzero demands data
// - after zero remaining, no new data while card still answers
// - either may abort; terminal abort discards transaction data
// - proactive 91 xx in other session; transfer resumes later
// - data bit clear: le only; data bit set: lc only
// - transfer payload is tag, length, value object
// - length one byte to 127, else 81 then one byte
module session_host #(
  parameter logic [7:0] CLA_BYTE = 8'h80,
  parameter logic [7:0] INS_MGMT = 8'h73,
  parameter logic [7:0] INS_XFER = 8'h75,
  parameter int         DEPTH    = 256,
  parameter int         RX_DEPTH = 256
) (
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             TX_VALID,
  output logic      [7:0]  TX_DATA,
  input  wire logic        TX_READY,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_LAST
);

  ////////////////////////////////////////////////////////////////////////
  chan_pkg::seq_e  state_reg;
  chan_pkg::seq_e  state_next;
  chan_pkg::xfer_s req_reg;
  chan_pkg::hdr_s  hdr;
  chan_pkg::sw_s   sw;
  chan_pkg::sw_s   sw_reg;
  logic [7:0]  pay_mem [DEPTH];
  logic [7:0]  rx_mem  [RX_DEPTH];
  logic        kind_reg;
  logic        rsp_reg;
  logic [7:0]  le_reg;
  logic [8:0]  pay_cnt_reg;
  logic [5:0]  pos_reg;
  logic [7:0]  first_tag_reg;
  logic        bad_reg;
  logic [8:0]  idx_reg;
  logic [8:0]  rx_wr_reg;
  logic [8:0]  rx_rd_reg;
  logic [7:0]  sw1_reg;
  logic [7:0]  sw2_reg;
  logic [7:0]  first_rx_reg;
  logic        rejected_reg;
  logic [3:0]  zero_sent_reg;
  logic [3:0]  card_more_reg;
  logic        tx_valid_reg;
  logic [7:0]  tx_data_reg;
  logic [7:0]  byte_next;
  logic [31:0] prdata_reg;
  logic [31:0] rdata;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        mapped;
  logic        acc;
  logic        wr;
  logic        payload_ok;
  logic        long_len;
  logic [8:0]  lc9;
  logic        lc_ok;
  logic        start;
  logic        tx_fire;

  assign PRDATA   = prdata_reg;
  assign PREADY   = pready_reg;
  assign PSLVERR  = pslverr_reg;
  assign TX_VALID = tx_valid_reg;
  assign TX_DATA  = tx_data_reg;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer on second access cycle
  assign acc = PSEL && PENABLE && pready_reg;
  assign wr  = acc && PWRITE && mapped;

  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    case (PADDR)
      `REG_CTRL:  rdata = {29'h0, rsp_reg, kind_reg, 1'b0};
      `REG_SESS:  rdata = {16'h0, req_reg.remain, req_reg.session,
                           3'b000, req_reg.data, req_reg.abort,
                           req_reg.retx};
      `REG_LEN:   rdata = {24'h0, le_reg};
      `REG_DATA:  rdata = {23'h0, pay_cnt_reg};
      `REG_STAT:  rdata = {sw1_reg, sw2_reg, 4'h0, sw_reg.session,
                           sw_reg.proact, sw_reg.retx, sw_reg.more,
                           sw_reg.fail, sw_reg.proactive,
                           sw_reg.ongoing, sw_reg.mac_err, sw_reg.ok,
                           rejected_reg, state_reg != chan_pkg::S_IDLE};
      `REG_SINFO: rdata = {first_rx_reg[5:0] == 6'h00,
                           5'h00, first_rx_reg[7:6],
                           7'h00, rx_wr_reg, card_more_reg,
                           zero_sent_reg};
      `REG_RX:    rdata = {23'h0, rx_rd_reg != rx_wr_reg,
                           rx_mem[rx_rd_reg[$clog2(RX_DEPTH)-1:0]]};
      default:    mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= PSEL && PENABLE && !pready_reg;
      if (PSEL && PENABLE && !pready_reg) begin
        prdata_reg  <= rdata;
        pslverr_reg <= !mapped;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      kind_reg <= 1'b0;
      rsp_reg  <= 1'b0;
      req_reg  <= '0;
      le_reg   <= 8'h00;
    end else if (wr && state_reg == chan_pkg::S_IDLE) begin
      case (PADDR)
        `REG_CTRL: begin
          kind_reg <= PWDATA[`CTRL_KIND];
          rsp_reg  <= PWDATA[`CTRL_RSP];
        end
        `REG_SESS: begin
          req_reg.retx    <= PWDATA[`SESS_RETX];
          req_reg.abort   <= PWDATA[`SESS_ABORT];
          req_reg.data    <= PWDATA[`SESS_DATA];
          req_reg.session <= PWDATA[`SESS_ID_LO+1:`SESS_ID_LO];
          req_reg.remain  <= PWDATA[`SESS_REM_LO+7:`SESS_REM_LO];
        end
        `REG_LEN: le_reg <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  assign start = wr && PADDR == `REG_CTRL && PWDATA[`CTRL_START] &&
                 state_reg == chan_pkg::S_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // payload buffer with object structure check
  always_ff @(posedge CLOCK) begin
    if (SRST || (wr && PADDR == `REG_CTRL && PWDATA[`CTRL_CLEAR])) begin
      pay_cnt_reg   <= 9'h000;
      pos_reg       <= 6'h00;
      first_tag_reg <= 8'h00;
      bad_reg       <= 1'b0;
    end else if (wr && PADDR == `REG_DATA &&
                 state_reg == chan_pkg::S_IDLE) begin
      if (pay_cnt_reg < 9'(DEPTH)) begin
        pay_mem[pay_cnt_reg[$clog2(DEPTH)-1:0]] <= PWDATA[7:0];
        pay_cnt_reg <= pay_cnt_reg + 9'h001;
      end else begin
        bad_reg <= 1'b1;
      end
      pos_reg <= (pos_reg == `OBJ_SIZE - 6'd1) ? 6'h00 : pos_reg + 6'd1;
      if (pos_reg == 6'h00) begin
        if (pay_cnt_reg == 9'h000) begin
          first_tag_reg <= PWDATA[7:0];
        end
        if ((PWDATA[7:0] != `TAG_MASTER && PWDATA[7:0] != `TAG_CONN) ||
            (pay_cnt_reg != 9'h000 &&
             (PWDATA[7:0] != first_tag_reg ||
              first_tag_reg == `TAG_MASTER))) begin
          bad_reg <= 1'b1;
        end
      end
      if (pos_reg == 6'd1 && PWDATA[7:0] != `OBJ_VAL_LEN) begin
        bad_reg <= 1'b1;
      end
    end
  end

  assign payload_ok = !bad_reg && pos_reg == 6'h00 &&
                      pay_cnt_reg != 9'h000 &&
                      (first_tag_reg == `TAG_CONN ||
                       pay_cnt_reg == {3'b000, `OBJ_SIZE});
  assign long_len = pay_cnt_reg > `LEN_SHORT_MAX;
  assign lc9      = pay_cnt_reg + (long_len ? 9'd3 : 9'd2);
  assign lc_ok    = pay_cnt_reg <= `LC_MAX && lc9 <= `LC_MAX;

  apdu_header u_hdr (
    .kind_xfer  (start ? PWDATA[`CTRL_KIND] : kind_reg),
    .term_rsp   (start ? PWDATA[`CTRL_RSP] : rsp_reg),
    .req        (req_reg),
    .payload_ok (payload_ok),
    .payload_nz (pay_cnt_reg != 9'h000),
    .lc_ok      (lc_ok),
    .zero_sent  (zero_sent_reg[req_reg.session]),
    .card_more  (card_more_reg[req_reg.session]),
    .hdr        (hdr)
  );

  ////////////////////////////////////////////////////////////////////////
  // command byte sequencer
  assign tx_fire = tx_valid_reg && TX_READY;

  always_comb begin
    state_next = state_reg;
    byte_next  = 8'h00;
    case (state_reg)
      chan_pkg::S_CLA: begin
        state_next = chan_pkg::S_INS;
        byte_next  = kind_reg ? INS_XFER : INS_MGMT;
      end
      chan_pkg::S_INS: begin
        state_next = chan_pkg::S_P1;
        byte_next  = hdr.p1;
      end
      chan_pkg::S_P1: begin
        state_next = chan_pkg::S_P2;
        byte_next  = hdr.p2;
      end
      chan_pkg::S_P2: begin
        if (hdr.has_lc) begin
          state_next = chan_pkg::S_LC;
          byte_next  = lc9[7:0];
        end else if (hdr.has_le) begin
          state_next = chan_pkg::S_LE;
          byte_next  = le_reg;
        end else begin
          state_next = chan_pkg::S_RESP;
        end
      end
      chan_pkg::S_LC: begin
        state_next = chan_pkg::S_TAG;
        byte_next  = kind_reg ? `TAG_XFER : `TAG_WRAP;
      end
      chan_pkg::S_TAG: begin
        if (long_len) begin
          state_next = chan_pkg::S_LEN1;
          byte_next  = `LEN_EXT;
        end else begin
          state_next = chan_pkg::S_LEN2;
          byte_next  = pay_cnt_reg[7:0];
        end
      end
      chan_pkg::S_LEN1: begin
        state_next = chan_pkg::S_LEN2;
        byte_next  = pay_cnt_reg[7:0];
      end
      chan_pkg::S_LEN2: begin
        state_next = chan_pkg::S_BODY;
        byte_next  = pay_mem[0];
      end
      chan_pkg::S_BODY: begin
        if (idx_reg + 9'h001 >= pay_cnt_reg) begin
          state_next = chan_pkg::S_RESP;
        end else begin
          byte_next = pay_mem[idx_reg[$clog2(DEPTH)-1:0] + 1'b1];
        end
      end
      chan_pkg::S_LE: state_next = chan_pkg::S_RESP;
      default: ;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_reg    <= chan_pkg::S_IDLE;
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
      idx_reg      <= 9'h000;
    end else begin
      case (state_reg)
        chan_pkg::S_IDLE: begin
          if (start && hdr.legal) begin
            state_reg    <= chan_pkg::S_CLA;
            tx_valid_reg <= 1'b1;
            tx_data_reg  <= CLA_BYTE;
            idx_reg      <= 9'h000;
          end
        end
        chan_pkg::S_RESP: begin
          if (RX_VALID && RX_LAST) begin
            state_reg <= chan_pkg::S_DONE;
          end
        end
        chan_pkg::S_DONE: state_reg <= chan_pkg::S_IDLE;
        default: begin
          if (tx_fire) begin
            state_reg    <= state_next;
            tx_data_reg  <= byte_next;
            tx_valid_reg <= state_next != chan_pkg::S_RESP;
            if (state_reg == chan_pkg::S_BODY) begin
              idx_reg <= idx_reg + 9'h001;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rejected_reg <= 1'b0;
    end else if (start) begin
      rejected_reg <= !hdr.legal;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // response capture and status word decode
  always_ff @(posedge CLOCK) begin
    if (SRST || (wr && PADDR == `REG_CTRL && PWDATA[`CTRL_CLEAR])) begin
      rx_wr_reg    <= 9'h000;
      rx_rd_reg    <= 9'h000;
      sw1_reg      <= 8'h00;
      sw2_reg      <= 8'h00;
      first_rx_reg <= 8'h00;
    end else begin
      if (start) begin
        rx_wr_reg <= 9'h000;
        rx_rd_reg <= 9'h000;
      end else if (state_reg == chan_pkg::S_RESP && RX_VALID) begin
        if (rx_wr_reg < 9'(RX_DEPTH)) begin
          rx_mem[rx_wr_reg[$clog2(RX_DEPTH)-1:0]] <= RX_DATA;
          rx_wr_reg <= rx_wr_reg + 9'h001;
        end
        if (rx_wr_reg == 9'h000) begin
          first_rx_reg <= RX_DATA;
        end
        sw1_reg <= sw2_reg;
        sw2_reg <= RX_DATA;
      end else if (acc && !PWRITE && PADDR == `REG_RX &&
                   rx_rd_reg != rx_wr_reg) begin
        rx_rd_reg <= rx_rd_reg + 9'h001;
      end
    end
  end

  sw_decode u_sw (
    .sw1 (sw1_reg),
    .sw2 (sw2_reg),
    .sw  (sw)
  );

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sw_reg <= '0;
    end else if (state_reg == chan_pkg::S_DONE) begin
      sw_reg <= sw;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-session transfer tracking
  for (genvar s = 0; s < 4; s++) begin : g_sess
    logic mine;
    assign mine = kind_reg && req_reg.session == 2'(s);
    always_ff @(posedge CLOCK) begin
      if (SRST) begin
        zero_sent_reg[s] <= 1'b0;
        card_more_reg[s] <= 1'b0;
      end else if (state_reg == chan_pkg::S_DONE) begin
        if (mine && req_reg.abort) begin
          zero_sent_reg[s] <= 1'b0;
          card_more_reg[s] <= 1'b0;
        end else begin
          if (mine && req_reg.data && req_reg.remain == 8'h00) begin
            zero_sent_reg[s] <= 1'b1;
          end
          if (sw.ongoing && sw.session == 2'(s)) begin
            card_more_reg[s] <= sw.more;
            if (!sw.more && !(mine && req_reg.data)) begin
              zero_sent_reg[s] <= 1'b0;
            end
          end
        end
      end
    end
  end

endmodule

// ==== core/sw_decode.sv ====
`timescale 1ns/1ps
`include "chan_defines.svh"

module sw_decode (
  input  wire logic [7:0] sw1,
  input  wire logic [7:0] sw2,
  output chan_pkg::sw_s   sw
);

  always_comb begin
    sw           = '0;
    sw.ok        = {sw1, sw2} == `SW_OK;
    sw.mac_err   = {sw1, sw2} == `SW_MAC_ERR;
    sw.ongoing   = sw1 == `SW1_ONGOING;
    sw.proactive = sw1 == `SW1_PROACTIVE;
    sw.fail      = !sw.ok && !sw.ongoing && !sw.proactive;
    sw.more      = sw.ongoing & sw2[7];
    sw.retx      = sw.ongoing & sw2[4];
    sw.proact    = sw.ongoing & sw2[3];
    sw.session   = sw2[2:1];
  end

endmodule

// ==== verif/card_model.sv ====
`timescale 1ns/1ps
module card_model (
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        TX_VALID,
  input  wire logic [7:0]  TX_DATA,
  output logic             TX_READY = 1'b0,
  output logic             RX_VALID = 1'b0,
  output logic      [7:0]  RX_DATA = 8'h00,
  output logic             RX_LAST = 1'b0,
  input  wire logic [7:0]  first,
  input  wire logic [15:0] sw,
  input  wire logic        slow
);
  logic [7:0] cmd [0:1023];
  int         ncmd = 0;
  int         idle = 0;
  int         k = 0;
  logic       pend = 1'b0;
  always @(posedge CLOCK) begin
    TX_READY <= slow ? ~TX_READY : 1'b1;
    RX_VALID <= 1'b0;
    RX_LAST <= 1'b0;
    // idle data line keeps moving
    RX_DATA <= ~RX_DATA;
    if (SRST) begin
      ncmd <= 0;
      pend <= 1'b0;
      TX_READY <= 1'b0;
    end else if (TX_VALID && TX_READY) begin
      cmd[ncmd] <= TX_DATA;
      ncmd <= ncmd + 1;
      pend <= 1'b1;
      idle <= 0;
      k <= 0;
    end else if (pend && !TX_VALID) begin
      idle <= idle + 1;
      if (idle > 1 && !(slow && idle[0])) begin
        RX_VALID <= 1'b1;
        RX_DATA <= k == 0 ? first : k == 1 ? sw[15:8] : sw[7:0];
        RX_LAST <= k == 2;
        k <= k + 1;
        if (k == 2) pend <= 1'b0;
      end
    end
  end
endmodule

// ==== verif/host_checker_asserts.sv ====
`timescale 1ns/1ps
module host_checker #(
  parameter logic [7:0] CLA_BYTE = 8'h80,
  parameter logic [7:0] INS_MGMT = 8'h73,
  parameter logic [7:0] INS_XFER = 8'h75
) (
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        TX_VALID,
  input wire logic [7:0]  TX_DATA,
  input wire logic        TX_READY,
  input wire logic        RX_VALID,
  input wire logic [7:0]  RX_DATA,
  input wire logic        RX_LAST
);
  logic       tk;
  logic [3:0] idx;
  logic [7:0] ins_q;
  logic [7:0] p1_q;
  logic [7:0] p2_q;
  assign tk = TX_VALID && TX_READY;
  // byte position within the command
  always_ff @(posedge CLOCK) begin
    if (SRST || (RX_VALID && RX_LAST)) idx <= 4'h0;
    else if (tk && idx != 4'hF) idx <= idx + 4'h1;
  end
  always_ff @(posedge CLOCK) begin
    if (tk && idx == 4'h1) ins_q <= TX_DATA;
    if (tk && idx == 4'h2) p1_q <= TX_DATA;
    if (tk && idx == 4'h3) p2_q <= TX_DATA;
  end
  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////////////////////////////////////////
  a_ready_second:
    assert property (PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY)
    else $error("pready not on second access cycle");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (PSLVERR |-> PREADY && PADDR > 8'h18)
    else $error("pslverr on mapped address");
  a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID
    && $stable(TX_DATA)) else $error("command byte not held");
  a_cla_first:
    assert property (tk && idx == 4'h0 |-> TX_DATA == CLA_BYTE)
    else $error("first byte not class");
  a_term_p1:
    assert property (tk && idx == 4'h2 && ins_q == INS_MGMT
      |-> TX_DATA == 8'h04) else $error("terminate p1 wrong");
  a_xfer_p1:
    assert property (tk && idx == 4'h2 && ins_q == INS_XFER
      |-> TX_DATA[5:3] == 3'h0 && !(TX_DATA[2] && TX_DATA[0]))
    else $error("transfer p1 reserved bits set");
  a_term_p2:
    assert property (tk && idx == 4'h3 && ins_q == INS_MGMT
      |-> TX_DATA == 8'h80 || TX_DATA == 8'hA0) else $error("terminate p2");
  a_p2_data:
    assert property (tk && idx == 4'h3 && ins_q == INS_XFER && TX_DATA != 0
      |-> p1_q[2] || p1_q[1]) else $error("remaining count without data");
  a_abort_short:
    assert property (tk && idx == 4'h3 && ins_q == INS_XFER && p1_q[1]
      |=> !TX_VALID) else $error("abort command not header only");
  a_fetch_le:
    assert property (tk && idx == 4'h4 && ((ins_q == INS_XFER && !p1_q[2])
      || (ins_q == INS_MGMT && p2_q == 8'hA0)) |=> !TX_VALID)
    else $error("fetch longer than expected length byte");
  a_wrap_tag:
    assert property (tk && idx == 4'h5 |-> TX_DATA ==
      (ins_q == INS_MGMT ? 8'h73 : 8'h80)) else $error("wrong object tag");
  a_quiet_after: assert property (RX_VALID && RX_LAST |=> !TX_VALID [*2])
    else $error("command sent while finishing response");
endmodule
bind session_host host_checker #(.CLA_BYTE(CLA_BYTE), .INS_MGMT(INS_MGMT),
  .INS_XFER(INS_XFER)) chk (.CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
  .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_LAST(RX_LAST));

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [15:0] sess;
    logic [3:0]  ctrl;
    logic [7:0]  obj;
    int          npay;
    logic [15:0] sw;
    logic [7:0]  p1;
    logic [7:0]  p2;
    int          ncmd;
  } row_s;
  logic        CLOCK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, slow;
  logic        TX_VALID, TX_READY, RX_VALID, RX_LAST, err;
  logic [7:0]  PADDR, TX_DATA, RX_DATA, first;
  logic [15:0] sw;
  logic [31:0] PWDATA, PRDATA, rd;
  int          errors, comparisons, cyc, base;
  row_s        rows [13];
  session_host dut (.CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
    .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_LAST(RX_LAST));
  card_model card (.CLOCK(CLOCK), .SRST(SRST), .TX_VALID(TX_VALID),
    .TX_DATA(TX_DATA), .TX_READY(TX_READY), .RX_VALID(RX_VALID),
    .RX_DATA(RX_DATA), .RX_LAST(RX_LAST), .first(first), .sw(sw),
    .slow(slow));
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  function automatic logic [7:0] pay(row_s r, int j);
    if (r.obj == 8'h00 || j % 34 > 1) return j[7:0];
    return j % 34 == 0 ? r.obj : 8'h20;
  endfunction
  function automatic logic [7:0] cb(int k);
    return card.cmd[base + k];
  endfunction
  function automatic logic [31:0] sexp(logic [15:0] s);
    logic [31:0] e;
    e = {s, 16'h0000};
    e[2] = s == 16'h9000;
    e[3] = s == 16'h9862;
    e[4] = s[15:8] == 8'h92;
    e[5] = s[15:8] == 8'h91;
    e[6] = !(e[2] | e[4] | e[5]);
    if (e[4]) e[11:7] = {s[2:1], s[3], s[4], s[7]};
    return e;
  endfunction
  task automatic run(input int i);
    row_s        r;
    logic [31:0] m;
    r = rows[i];
    first <= {i[1:0], 6'h00};
    sw <= r.sw;
    slow <= i[0];
    apb(1'b1, 8'h00, 32'h00000008);
    for (int k = 0; k < r.npay; k++) apb(1'b1, 8'h0C, {24'h0, pay(r, k)});
    apb(1'b1, 8'h04, {16'h0000, r.sess});
    base = card.ncmd;
    apb(1'b1, 8'h00, {28'h0, r.ctrl});
    do apb(1'b0, 8'h10, 32'h0); while (rd[0] !== 1'b0 && cyc < 20000);
    m = r.ncmd == 0 ? 32'h3 : r.sw[15:8] == 8'h92 ? '1 : 32'hFFFFF07F;
    chk(rd & m, (r.ncmd == 0 ? 32'h2 : sexp(r.sw)) & m);
    chk(card.ncmd - base, r.ncmd);
    if (r.ncmd > 0) begin
      chk(cb(0), 8'h80);
      chk(cb(1), r.ctrl[1] ? 8'h75 : 8'h73);
      chk(cb(2), r.p1);
      chk(cb(3), r.p2);
      if (r.ncmd == 5) chk(cb(4), 8'h10);
      if (r.ncmd > 5) begin
        chk(cb(4), r.ncmd - 5);
        chk(cb(5), r.obj == 0 ? 8'h80 : 8'h73);
        chk(cb(6), r.npay > 127 ? 8'h81 : r.npay);
        chk(cb(r.ncmd - 1), pay(r, r.npay - 1));
      end
      apb(1'b0, 8'h14, 32'h0);
      chk({rd[31], rd[25:24]}, {1'b1, i[1:0]});
      apb(1'b0, 8'h18, 32'h0);
      chk(rd[8:0], {1'b1, i[1:0], 6'h00});
    end
    $display("row %0d done", i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    {SRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'b1, 43'h0};
    {first, sw, slow} = 25'h0;
    rows = '{'{16'h0244, 4'h3, 8'h00, 4, 16'h9281, 8'h44, 8'h02, 11},
      '{16'h00C4, 4'h3, 8'h00, 1, 16'h9204, 8'hC4, 8'h00, 8},
      '{16'h0081, 4'h3, 8'h00, 0, 16'h9218, 8'h81, 8'h00, 5},
      '{16'h0002, 4'h3, 8'h00, 0, 16'h9000, 8'h02, 8'h00, 4},
      '{16'h0000, 4'h1, 8'h88, 34, 16'h9000, 8'h04, 8'h80, 41},
      '{16'h0000, 4'h1, 8'h8B, 68, 16'h9862, 8'h04, 8'h80, 75},
      '{16'h0000, 4'h5, 8'h00, 0, 16'h6A84, 8'h04, 8'hA0, 5},
      '{16'h0044, 4'h3, 8'h00, 2, 16'h9282, 8'h44, 8'h00, 9},
      '{16'h0300, 4'h3, 8'h00, 0, 16'h9000, 8'h00, 8'h03, 0},
      '{16'h0044, 4'h3, 8'h00, 1, 16'h9000, 8'h44, 8'h00, 0},
      '{16'h0080, 4'h3, 8'h00, 0, 16'h9105, 8'h80, 8'h00, 5},
      '{16'h0000, 4'h1, 8'h88, 68, 16'h9000, 8'h04, 8'h80, 0},
      '{16'h0004, 4'h3, 8'h00, 130, 16'h9200, 8'h04, 8'h00, 138}};
    repeat (3) @(posedge CLOCK);
    SRST <= 1'b0;
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk(err, 1'b1);
    $display("reset and unmapped done");
    apb(1'b1, 8'h08, 32'h10);
    for (int i = 0; i < 13; i++) run(i);
    // reset in the middle of a command
    apb(1'b1, 8'h0C, 32'h5);
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b1, 8'h00, 32'h3);
    SRST <= 1'b1;
    repeat (3) @(posedge CLOCK);
    SRST <= 1'b0;
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    $display("mid reset done");
    run(1);
    print_verdict;
  end
endmodule
